// file: hw/ptm_paired_timer.sv
`timescale 1ns/1ps
// How it works
// - Lower word low, upper word high
// - Cascade uses only lower control, clock, gate
// - Cascade interrupt goes to upper flag, enable
// - Split mode: two independent timers or counters
// - Only lower prescaler output is retimed
// - Cascade timer counts cycles, wraps at period
// - Lower count read latches upper into holding
// - Cascade lower write copies holding into upper word
// - Cascade counter counts synchronised external edges
// - Stop-in-idle bit freezes count during idle
// - Gated mode counts cycles while gate high
// - Cascade gating follows lower control; upper gate ignored
// - Gate fall stops accumulation, keeps count
// - Period match or gate fall sets flag
// - Cascade period match pulses converter trigger
// - Prescaler divides by 1, 8, 64, 256
module ptm_paired_timer
   import ptm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [15:0] lower_timer_control,
   input wire logic [15:0] upper_timer_control,
   input wire logic [15:0] lower_period_word,
   input wire logic [15:0] upper_period_word,
   input wire logic lower_count_wr,
   input wire logic lower_count_rd,
   input wire logic upper_count_wr,
   input wire logic holding_wr,
   input wire logic [15:0] write_data,
   input wire logic cpu_idle,
   input wire logic gate_clock_pin,
   input wire logic upper_clock_pin,
   input wire logic lower_irq_enable,
   input wire logic upper_timer_irq_enable,
   input wire logic lower_irq_clear,
   input wire logic upper_irq_clear,
   output logic [15:0] lower_count_word,
   output logic [15:0] upper_count_word,
   output logic [15:0] upper_word_holding,
   output logic lower_irq_flag,
   output logic upper_timer_irq_flag,
   output logic lower_irq,
   output logic upper_irq,
   output logic adc_trigger
);

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [1:0] pin_s1;   // First stage, read only by second
   logic [1:0] pin_s2;   // Second stage
   logic [1:0] pin_s3;   // Third stage
   logic [1:0] pin_lvl;  // Accepted level
   logic [1:0] pin_prev; // Accepted level one cycle back
   logic [1:0] pin_rise; // Rising edge of accepted level
   logic [1:0] pin_fall; // Falling edge of accepted level

   // Three stages; a change is taken once stages two and three agree
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pin_s1 <= 2'h0;
         pin_s2 <= 2'h0;
         pin_s3 <= 2'h0;
         pin_lvl <= 2'h0;
         pin_prev <= 2'h0;
      end else begin
         pin_s1 <= {upper_clock_pin, gate_clock_pin};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         for (int i = 0; i < 2; i++) begin
            if (pin_s2[i] == pin_s3[i]) begin
               pin_lvl[i] <= pin_s3[i];
            end
         end
         pin_prev <= pin_lvl;
      end
   end

   assign pin_rise = pin_lvl & ~pin_prev;
   assign pin_fall = pin_prev & ~pin_lvl;

   // ************************************************************
   // Control decode
   // ************************************************************
   logic mode32; // Cascaded operation
   logic l_on;   // Lower timer on
   logic u_on;   // Upper timer on
   logic l_gate; // Lower gated accumulation
   logic u_gate; // Upper gated accumulation
   logic l_run;  // Lower may count now
   logic u_run;  // Upper may count now
   logic l_src;  // Lower raw tick
   logic u_src;  // Upper raw tick

   assign mode32 = lower_timer_control[PTM_T32_BIT];
   assign l_on = lower_timer_control[PTM_ON_BIT];
   assign u_on = upper_timer_control[PTM_ON_BIT];
   assign l_gate = lower_timer_control[PTM_GATE_BIT]
                   && !lower_timer_control[PTM_CS_BIT];
   assign u_gate = upper_timer_control[PTM_GATE_BIT]
                   && !upper_timer_control[PTM_CS_BIT];

   // Idle halts only when the stop-in-idle bit is set
   assign l_run = l_on && !(cpu_idle
                  && lower_timer_control[PTM_IDLE_BIT]);
   assign u_run = u_on && !(cpu_idle
                  && upper_timer_control[PTM_IDLE_BIT]);

   // Source: external edge, gated cycle, or every cycle
   always_comb begin
      if (lower_timer_control[PTM_CS_BIT]) begin
         l_src = pin_rise[0];
      end else if (l_gate) begin
         l_src = pin_lvl[0];
      end else begin
         l_src = 1'b1;
      end
   end

   // Upper control is dead in cascade; its gate bit too
   always_comb begin
      if (mode32) begin
         u_src = 1'b0;
      end else if (upper_timer_control[PTM_CS_BIT]) begin
         u_src = pin_rise[1];
      end else if (u_gate) begin
         u_src = pin_lvl[1];
      end else begin
         u_src = 1'b1;
      end
   end

   // ************************************************************
   // Prescalers
   // ************************************************************
   logic tick_l; // Lower prescaled tick
   logic tick_u; // Upper prescaled tick

   ptm_prescaler #(.SYNC_OUT(1'b1)) u_lower_ps (
      .ref_clk(ref_clk),
      .reset(reset),
      .clear(!l_on || lower_count_wr || (mode32 && upper_count_wr)),
      .tick_in(l_run && l_src),
      .prescale_select(lower_timer_control[PTM_PS_HI:PTM_PS_LO]),
      .tick_out(tick_l)
   );

   ptm_prescaler #(.SYNC_OUT(1'b0)) u_upper_ps (
      .ref_clk(ref_clk),
      .reset(reset),
      .clear(!u_on || mode32 || upper_count_wr),
      .tick_in(u_run && u_src),
      .prescale_select(upper_timer_control[PTM_PS_HI:PTM_PS_LO]),
      .tick_out(tick_u)
   );

   // ************************************************************
   // Match detection
   // ************************************************************
   logic [31:0] count32;  // Combined count
   logic [31:0] period32; // Combined period
   logic hit32;           // Cascade period match
   logic hit_l;           // Lower split match
   logic hit_u;           // Upper split match
   logic gate_evt_l;      // Lower gate falling edge event
   logic gate_evt_u;      // Upper gate falling edge event

   assign count32 = {upper_count_word, lower_count_word};
   assign period32 = {upper_period_word, lower_period_word};
   assign hit32 = mode32 && tick_l && (count32 == period32);
   assign hit_l = !mode32 && tick_l
                  && (lower_count_word == lower_period_word);
   assign hit_u = !mode32 && tick_u
                  && (upper_count_word == upper_period_word);
   assign gate_evt_l = l_on && l_gate && pin_fall[0];
   assign gate_evt_u = !mode32 && u_on && u_gate && pin_fall[1];

   // ************************************************************
   // Count words
   // ************************************************************
   // Lower word: a write wins over a tick
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         lower_count_word <= PTM_COUNT_RST;
      end else if (lower_count_wr) begin
         lower_count_word <= write_data;
      end else if (tick_l) begin
         if (hit32 || hit_l) begin
            lower_count_word <= PTM_COUNT_RST;
         end else begin
            lower_count_word <= lower_count_word + 16'h0001;
         end
      end
   end

   // Upper word: carries from lower in cascade
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         upper_count_word <= PTM_COUNT_RST;
      end else if (upper_count_wr) begin
         upper_count_word <= write_data;
      end else if (lower_count_wr && mode32) begin
         upper_count_word <= upper_word_holding;
      end else if (mode32 && tick_l) begin
         if (hit32) begin
            upper_count_word <= PTM_COUNT_RST;
         end else if (lower_count_word == PTM_WORD_ONES) begin
            upper_count_word <= upper_count_word + 16'h0001;
         end
      end else if (tick_u) begin
         if (hit_u) begin
            upper_count_word <= PTM_COUNT_RST;
         end else begin
            upper_count_word <= upper_count_word + 16'h0001;
         end
      end
   end

   // Holding word: a direct write beats a read capture
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         upper_word_holding <= PTM_COUNT_RST;
      end else if (holding_wr) begin
         upper_word_holding <= write_data;
      end else if (lower_count_rd) begin
         upper_word_holding <= upper_count_word;
      end
   end

   // ************************************************************
   // Flags, interrupts, trigger
   // ************************************************************
   logic set_l; // Lower flag event
   logic set_u; // Upper flag event

   assign set_l = !mode32 && (hit_l || gate_evt_l);
   assign set_u = mode32 ? (hit32 || gate_evt_l)
                         : (hit_u || gate_evt_u);

   // Set wins over a clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         lower_irq_flag <= 1'b0;
         upper_timer_irq_flag <= 1'b0;
      end else begin
         lower_irq_flag <= set_l || (lower_irq_flag && !lower_irq_clear);
         upper_timer_irq_flag <= set_u
            || (upper_timer_irq_flag && !upper_irq_clear);
      end
   end

   // Interrupt lines follow flag and enable one cycle later
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         lower_irq <= 1'b0;
         upper_irq <= 1'b0;
      end else begin
         lower_irq <= lower_irq_flag && lower_irq_enable;
         upper_irq <= upper_timer_irq_flag && upper_timer_irq_enable;
      end
   end

   // One-cycle converter trigger on upper period match
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         adc_trigger <= 1'b0;
      end else begin
         adc_trigger <= hit32 || hit_u;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   logic quiet; // No count word write this cycle
   assign quiet = !lower_count_wr && !upper_count_wr;

   property p_cascade_step;
      (mode32 && tick_l && !hit32 && quiet)
         |=> (count32 == $past(count32) + 32'h1);
   endproperty
   a_cascade_step: assert property (p_cascade_step)
      else $error("cascade count did not advance by one");

   property p_cascade_wrap;
      (hit32 && quiet) |=> (count32 == 32'h0);
   endproperty
   a_cascade_wrap: assert property (p_cascade_wrap)
      else $error("cascade count did not wrap at period");

   property p_read_latch;
      (lower_count_rd && !holding_wr)
         |=> (upper_word_holding == $past(upper_count_word));
   endproperty
   a_read_latch: assert property (p_read_latch)
      else $error("holding word missed upper count on read");

   property p_write_copy;
      (lower_count_wr && mode32 && !upper_count_wr)
         |=> (upper_count_word == $past(upper_word_holding))
             && (lower_count_word == $past(write_data));
   endproperty
   a_write_copy: assert property (p_write_copy)
      else $error("holding word not copied on lower write");

   property p_cascade_flag;
      hit32 |=> upper_timer_irq_flag && !$rose(lower_irq_flag);
   endproperty
   a_cascade_flag: assert property (p_cascade_flag)
      else $error("cascade match did not set upper flag");

   sequence s_idle_stop;
      (cpu_idle && lower_timer_control[PTM_IDLE_BIT])[*2]
         ##0 !lower_count_wr;
   endsequence
   property p_idle_hold;
      s_idle_stop |=> $stable(lower_count_word);
   endproperty
   a_idle_hold: assert property (p_idle_hold)
      else $error("lower count moved during idle stop");

   property p_gate_low_hold;
      (l_gate && !pin_lvl[0])[*2] ##0 !lower_count_wr
         |=> $stable(lower_count_word);
   endproperty
   a_gate_low_hold: assert property (p_gate_low_hold)
      else $error("lower count moved with gate low");

   property p_gate_fall_flag;
      (gate_evt_l && mode32) |=> upper_timer_irq_flag;
   endproperty
   a_gate_fall_flag: assert property (p_gate_fall_flag)
      else $error("gate fall did not set upper flag");

   property p_adc_pulse;
      hit32 |=> adc_trigger ##1 (!adc_trigger || $past(hit32 || hit_u));
   endproperty
   a_adc_pulse: assert property (p_adc_pulse)
      else $error("converter trigger missing after match");

   property p_split_wrap;
      (hit_l && !lower_count_wr)
         |=> (lower_count_word == 16'h0000) && lower_irq_flag;
   endproperty
   a_split_wrap: assert property (p_split_wrap)
      else $error("lower split timer did not wrap and flag");

   c_cascade_match: cover property (hit32);
   c_gate_end: cover property (gate_evt_l && mode32);
   c_upper_split_match: cover property (hit_u);

endmodule : ptm_paired_timer

// file: shared/ptm_pkg.sv
package ptm_pkg;

   // ************************************************************
   // Control word field positions
   // ************************************************************
   localparam int PTM_ON_BIT = 15;      // Timer on
   localparam int PTM_IDLE_BIT = 13;    // Stop while CPU idle
   localparam int PTM_GATE_BIT = 6;     // Gated accumulation
   localparam int PTM_PS_HI = 5;        // Prescale select, high bit
   localparam int PTM_PS_LO = 4;        // Prescale select, low bit
   localparam int PTM_T32_BIT = 3;      // Cascade into 32 bits
   localparam int PTM_CS_BIT = 1;       // External clock source

   // ************************************************************
   // Reset values and all-ones word
   // ************************************************************
   localparam logic [15:0] PTM_COUNT_RST = 16'h0000;
   localparam logic [15:0] PTM_WORD_ONES = 16'hFFFF;
   localparam logic [7:0] PTM_PS_RST = 8'h00;

   // ************************************************************
   // Prescale terminal counts (divide minus one)
   // ************************************************************
   localparam logic [7:0] PTM_DIV1_LAST = 8'h00;
   localparam logic [7:0] PTM_DIV8_LAST = 8'h07;
   localparam logic [7:0] PTM_DIV64_LAST = 8'h3F;
   localparam logic [7:0] PTM_DIV256_LAST = 8'hFF;

   // Select code to last prescaler count
   function automatic logic [7:0] ptm_div_last(input logic [1:0] sel);
      logic [7:0] last;
      last = PTM_DIV1_LAST;
      unique case (sel)
         2'h0: last = PTM_DIV1_LAST;
         2'h1: last = PTM_DIV8_LAST;
         2'h2: last = PTM_DIV64_LAST;
         2'h3: last = PTM_DIV256_LAST;
      endcase
      return last;
   endfunction : ptm_div_last

endpackage : ptm_pkg

// file: hw/ptm_prescaler.sv
`timescale 1ns/1ps
module ptm_prescaler
   import ptm_pkg::*;
#(
   parameter bit SYNC_OUT = 1'b1
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clear,
   input wire logic tick_in,
   input wire logic [1:0] prescale_select,
   output logic tick_out
);

   // ************************************************************
   // Divider counter
   // ************************************************************
   logic [7:0] count; // Input ticks seen in this period
   logic hit;         // Last input tick of the period

   assign hit = tick_in && (count == ptm_div_last(prescale_select));

   // Counter clears on reset, timer off or count write
   always_ff @(posedge ref_clk) begin
      if (reset || clear) begin
         count <= PTM_PS_RST;
      end else if (tick_in) begin
         count <= hit ? PTM_PS_RST : count + 8'h01;
      end
   end

   // ************************************************************
   // Output stage
   // ************************************************************
   generate
      if (SYNC_OUT) begin : g_sync
         // Retimed output; costs one cycle of latency but suits
         // fast external clocks
         logic tick_q;
         always_ff @(posedge ref_clk) begin
            if (reset || clear) begin
               tick_q <= 1'b0;
            end else begin
               tick_q <= hit;
            end
         end
         assign tick_out = tick_q;
      end else begin : g_direct
         // Direct output, no retiming
         assign tick_out = hit;
      end
   endgenerate

endmodule : ptm_prescaler

// file: verification/ptm_pin_source.sv
`timescale 1ns/1ps
// ************************************************************
// Far side pin: external counting clock or gate level
// ************************************************************
module ptm_pin_source (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic pulse_en,
   input wire logic [7:0] half_cycles,
   input wire logic level,
   output logic pin
);
   logic [7:0] phase; // Cycles spent in current half period

   // Toggle each half period in a burst, else follow the level
   // Clock stands still between bursts, so idle edges never leak in
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         phase <= 8'h00;
         pin <= 1'b0;
      end else if (!pulse_en) begin
         phase <= 8'h00;
         pin <= level;
      end else if (phase == half_cycles - 8'h01) begin
         phase <= 8'h00;
         pin <= ~pin;
      end else begin
         phase <= phase + 8'h01;
      end
   end
endmodule : ptm_pin_source

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import ptm_pkg::*;
;
   // ************************************************************
   // Signals
   // ************************************************************
   localparam logic [15:0] c_on = 16'h0001 << PTM_ON_BIT;
   localparam logic [15:0] c_idle = 16'h0001 << PTM_IDLE_BIT;
   localparam logic [15:0] c_gate = 16'h0001 << PTM_GATE_BIT;
   localparam logic [15:0] c_t32 = 16'h0001 << PTM_T32_BIT;
   localparam logic [15:0] c_cs = 16'h0001 << PTM_CS_BIT;
   logic ref_clk, reset, lo_wr, lo_rd, up_wr, hold_wr, cpu_idle;
   logic [15:0] lo_ctl, up_ctl, lo_per, up_per, wdata;
   logic lo_ie, up_ie, lo_clr, up_clr, pulse_en, level, g_pin, u_pin;
   logic [15:0] lo_cnt, up_cnt, hold; // Count and holding words
   logic lo_flag, up_flag, lo_irq, up_irq, adc;
   logic [31:0] c1; // Snapshot of the cascaded count
   int err_count, n_tests; // Mismatches and comparisons

   ptm_paired_timer DUT (.ref_clk(ref_clk), .reset(reset),
      .lower_timer_control(lo_ctl), .upper_timer_control(up_ctl),
      .lower_period_word(lo_per), .upper_period_word(up_per),
      .lower_count_wr(lo_wr), .lower_count_rd(lo_rd),
      .upper_count_wr(up_wr), .holding_wr(hold_wr), .write_data(wdata),
      .cpu_idle(cpu_idle), .gate_clock_pin(g_pin), .upper_clock_pin(u_pin),
      .lower_irq_enable(lo_ie), .upper_timer_irq_enable(up_ie),
      .lower_irq_clear(lo_clr), .upper_irq_clear(up_clr),
      .lower_count_word(lo_cnt), .upper_count_word(up_cnt),
      .upper_word_holding(hold), .lower_irq_flag(lo_flag),
      .upper_timer_irq_flag(up_flag), .lower_irq(lo_irq),
      .upper_irq(up_irq), .adc_trigger(adc));
   // Upper pin runs faster; cascade must ignore it
   ptm_pin_source u_lo_pin (.ref_clk(ref_clk), .reset(reset),
      .pulse_en(pulse_en), .half_cycles(8'h04), .level(level), .pin(g_pin));
   ptm_pin_source u_up_pin (.ref_clk(ref_clk), .reset(reset),
      .pulse_en(pulse_en), .half_cycles(8'h02), .level(level), .pin(u_pin));

   // 40 MHz reference clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // ************************************************************
   // Tasks
   // ************************************************************
   function automatic logic [31:0] cnt32();
      return {up_cnt, lo_cnt};
   endfunction : cnt32

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Window check; an unknown count never lands inside
   task automatic chk_rng(input logic [31:0] got, lo, hi);
      n_tests++;
      if (^got === 1'bx || got < lo || got > hi) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask : chk_rng

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : step

   // Control, period and enables change together on an edge
   task automatic cfg(input logic [15:0] lc, uc, lp, upp,
                      input logic [1:0] ie);
      @(posedge ref_clk);
      lo_ctl <= lc;
      up_ctl <= uc;
      lo_per <= lp;
      up_per <= upp;
      {up_ie, lo_ie} <= ie;
   endtask : cfg

   // One-cycle strobe: 0 lower wr, 1 upper wr, 2 hold wr, 3 rd, 4 clr
   task automatic pulse(input int which, input logic [15:0] d);
      @(posedge ref_clk);
      wdata <= d;
      case (which)
         0: lo_wr <= 1'b1;
         1: up_wr <= 1'b1;
         2: hold_wr <= 1'b1;
         3: lo_rd <= 1'b1;
         default: {lo_clr, up_clr} <= 2'h3;
      endcase
      @(posedge ref_clk);
      {lo_wr, up_wr, hold_wr, lo_rd, lo_clr, up_clr} <= 6'h00;
   endtask : pulse

   // Bounded wait: 0 converter trigger, 1 lower flag, 2 upper flag
   task automatic wait_on(input int sel, input int lim);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < lim && !hit; i++) begin
         step(1);
         hit = (sel == 0) ? adc === 1'b1 :
               (sel == 1) ? lo_flag === 1'b1 : up_flag === 1'b1;
      end
      if (!hit) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
         stop_test();
      end
   endtask : wait_on

   // Stop, zero both words and flags, keeping the cascade choice
   task automatic zero(input logic [15:0] lc);
      cfg(lc, 16'h0000, 16'hFFFF, 16'hFFFF, 2'h0);
      pulse(2, 16'h0000);
      pulse(0, 16'h0000);
      pulse(1, 16'h0000);
      pulse(4, 16'h0000);
   endtask : zero

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_hold();
      zero(c_t32);
      pulse(1, 16'h1234);
      pulse(3, 16'h0000);
      #1 chk(hold, 16'h1234);
      pulse(2, 16'hABCD);
      #1 chk(up_cnt, 16'h1234);
      pulse(0, 16'h0005);
      #1 chk(cnt32(), 32'hABCD0005);
      $display("holding register test done");
   endtask : t_hold

   // Carry across words and wrap; upper control set to all ones
   task automatic t_cascade();
      zero(c_t32);
      pulse(2, 16'h0001);
      pulse(0, 16'hFFFE);
      #1 chk(cnt32(), 32'h0001FFFE);
      cfg(c_on | c_t32, 16'hFFFF, 16'h0001, 16'h0002, 2'h3);
      wait_on(0, 20);
      chk(cnt32(), 32'h00000000);
      chk({lo_flag, up_flag}, 32'h00000001);
      step(1);
      chk({lo_irq, up_irq, adc}, 32'h00000002);
      $display("cascade match test done");
   endtask : t_cascade

   task automatic t_prescale();
      int d;
      for (int s = 0; s < 4; s++) begin
         d = (s == 0) ? 1 : (s == 1) ? 8 : (s == 2) ? 64 : 256;
         zero(16'h0000);
         cfg(c_on | (16'(s) << PTM_PS_LO), 16'h0000, 16'hFFFF, 16'hFFFF,
             2'h0);
         step(4 * d + d / 2);
         chk_rng(lo_cnt, 32'h00000002, 32'h00000004);
      end
      $display("prescaler test done");
   endtask : t_prescale

   // Short lower period, long upper period, only lower interrupt enabled
   task automatic t_split();
      zero(16'h0000);
      cfg(c_on, c_on, 16'h0003, 16'h0014, 2'h1);
      wait_on(1, 20);
      chk({lo_cnt, up_flag}, 32'h00000000);
      step(1);
      chk(lo_irq, 32'h00000001);
      wait_on(0, 40);
      chk({up_cnt, up_flag}, 32'h00000001);
      step(1);
      chk(up_irq, 32'h00000000);
      $display("split timers test done");
   endtask : t_split

   // Ten lower pin edges while the upper pin toggles twice as fast
   task automatic t_ext();
      zero(c_t32 | c_cs);
      cfg(c_on | c_t32 | c_cs, c_on | c_cs, 16'hFFFF, 16'hFFFF, 2'h0);
      @(posedge ref_clk);
      pulse_en <= 1'b1;
      repeat (80) @(posedge ref_clk);
      pulse_en <= 1'b0;
      step(12);
      chk(cnt32(), 32'h0000000A);
      // Split counters: each word counts its own pin's rising edges
      zero(c_cs);
      cfg(c_on | c_cs, c_on | c_cs, 16'hFFFF, 16'hFFFF, 2'h0);
      @(posedge ref_clk);
      pulse_en <= 1'b1;
      repeat (80) @(posedge ref_clk);
      pulse_en <= 1'b0;
      step(12);
      chk(cnt32(), 32'h0014000A);
      $display("external count test done");
   endtask : t_ext

   task automatic t_idle();
      zero(c_t32);
      cfg(c_on | c_t32 | c_idle, 16'h0000, 16'hFFFF, 16'hFFFF, 2'h0);
      @(posedge ref_clk);
      cpu_idle <= 1'b1;
      step(4);
      c1 = cnt32();
      step(10);
      chk(cnt32(), c1);
      @(posedge ref_clk);
      cpu_idle <= 1'b0;
      step(10);
      chk_rng(cnt32(), c1 + 6, c1 + 10);
      cfg(c_on | c_t32, 16'h0000, 16'hFFFF, 16'hFFFF, 2'h0);
      cpu_idle <= 1'b1;
      step(1);
      c1 = cnt32();
      step(10);
      chk_rng(cnt32(), c1 + 8, c1 + 11);
      @(posedge ref_clk);
      cpu_idle <= 1'b0;
      $display("idle test done");
   endtask : t_idle

   // Gate high for 20 cycles; upper gate bit alone would do nothing
   task automatic t_gate();
      zero(c_t32);
      cfg(c_on | c_t32 | c_gate, c_gate, 16'hFFFF, 16'hFFFF, 2'h0);
      @(posedge ref_clk);
      level <= 1'b1;
      repeat (20) @(posedge ref_clk);
      level <= 1'b0;
      step(12);
      c1 = cnt32();
      chk_rng(c1, 32'h00000012, 32'h00000016);
      step(5);
      chk(cnt32(), c1);
      chk({lo_flag, up_flag}, 32'h00000001);
      $display("gate test done");
   endtask : t_gate

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      err_count = 0;
      n_tests = 0;
      reset = 1'b1;
      {lo_ctl, up_ctl, lo_per, up_per, wdata} = '0;
      {lo_wr, lo_rd, up_wr, hold_wr, cpu_idle} = 5'h00;
      {lo_ie, up_ie, lo_clr, up_clr, pulse_en, level} = 6'h00;
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      step(1);
      chk({lo_cnt, up_cnt}, 32'h00000000);
      chk({hold, lo_flag, up_flag, lo_irq, up_irq, adc}, 32'h00000000);
      t_hold();
      t_cascade();
      t_prescale();
      t_split();
      t_ext();
      t_idle();
      t_gate();
      stop_test();
   end
endmodule : tb_top
